// ===== hdl/csf_fifo.v
// Behaviour
// - write enable stores word at next free slot
// - words leave in the order written
// - full high when every slot occupied
// - empty high exactly when nothing stored
// - fill fraction, point above top bit
// - look-ahead mode shows oldest word unasked
// - standard mode outputs word only on read
// - output register adds exactly one cycle
// - depth parameter from 16 to 64K words
// - optional count output gives stored words
// - optional near-empty and near-full flags
// - optional reset input empties the queue
// - optional clock enable input
// - output register resets to programmed value
`include "csf_map.vh"

module csf_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 1024,
    parameter FRAC_BITS = 1,
    parameter LOOKAHEAD = 0,
    parameter OUT_REG = 0,
    parameter HAS_RST = 1,
    parameter HAS_CE = 1,
    parameter HAS_COUNT = 1,
    parameter HAS_NEAR_EMPTY = 1,
    parameter HAS_NEAR_FULL = 1,
    parameter [WIDTH-1:0] OUT_RESET_VALUE = {WIDTH{1'b0}}
)(
    // clock and reset
    input wire core_clk,
    input wire reset_n,
    // optional queue controls
    input wire fifoReset,
    input wire clockEnable,
    // producer side
    input wire writeEnable,
    input wire [WIDTH-1:0] writeData,
    output wire full,
    // consumer side
    input wire readEnable,
    output wire [WIDTH-1:0] readData,
    output wire readValid,
    output wire empty,
    // fill status
    output wire [FRAC_BITS-1:0] fillFraction,
    output wire [$clog2(DEPTH):0] wordCount,
    output wire nearEmptyFlag,
    output wire nearFullFlag,
    // wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // interrupt
    output wire irq
);

localparam AW = $clog2(DEPTH);
localparam [AW:0] FULL_COUNT = DEPTH;
localparam [`CSF_LVL_W-1:0] FULL_LVL = DEPTH;

function [31:0] byteMerge;
    input [31:0] oldV;
    input [31:0] newV;
    input [3:0] sel;
    integer i;
    begin
        for (i = 0; i < 4; i = i + 1) begin
            byteMerge[i*8 +: 8] = sel[i] ? newV[i*8 +: 8] : oldV[i*8 +: 8];
        end
    end
endfunction

reg [AW-1:0] wrPtr;
reg [AW-1:0] rdPtr;
reg [AW:0] count;
reg stdValid;
reg [WIDTH-1:0] pipeData;
reg pipeValid;
reg flushReq;
reg [`CSF_EV_W-1:0] intStatus;
reg [`CSF_EV_W-1:0] intMask;
reg [`CSF_LVL_W-1:0] nearEmptyLvl;
reg [`CSF_LVL_W-1:0] nearFullLvl;
reg fullQ;
reg emptyQ;
reg nearEmptyQ;
reg nearFullQ;
reg [31:0] next_rdata;
reg [`CSF_EV_W-1:0] next_intStatus;

wire [WIDTH-1:0] ramData;
wire [`CSF_LVL_W-1:0] count17;
wire [`CSF_EV_W-1:0] events;
wire [`CSF_EV_W-1:0] intClear;
wire [31:0] statusWord;
wire [31:0] maskMerged;
wire [31:0] nearEmptyMerged;
wire [31:0] nearFullMerged;

// queue state only moves while enabled, except for a clear; the bus keeps running regardless
wire ceOn = (HAS_CE != 0) ? clockEnable : 1'b1;

// a flush from software clears the queue like the optional reset input, but one edge after the acknowledged write
wire clear = !reset_n || ((HAS_RST != 0) && fifoReset) || flushReq;

wire isFull = (count == FULL_COUNT);
wire isEmpty = (count == {(AW+1){1'b0}});

wire push = writeEnable && !isFull && ceOn;
wire pop = readEnable && !isEmpty && ceOn;

wire overflow = writeEnable && isFull && ceOn;
wire underflow = readEnable && isEmpty && ceOn;

// look-ahead keeps the ram output tracking the head: the address moves
// ahead on a pop so the next word is already latched one edge later
wire ramReadEn = (LOOKAHEAD != 0) ? ceOn : pop;
wire [AW-1:0] ramReadAddr = ((LOOKAHEAD != 0) && pop) ?
    rdPtr + {{(AW-1){1'b0}}, 1'b1} : rdPtr;

wire headValid = (LOOKAHEAD != 0) ? !isEmpty : stdValid;

wire wbReq = wb_cyc_i && wb_stb_i;
wire wbWrite = wbReq && wb_we_i && wb_ack_o;

assign count17 = {{(`CSF_LVL_W-AW-1){1'b0}}, count};

// merged bus words are cut back to each register's own width
assign maskMerged = byteMerge({26'h0, intMask}, wb_dat_i, wb_sel_i);
assign nearEmptyMerged = byteMerge({15'h0, nearEmptyLvl}, wb_dat_i,
    wb_sel_i);
assign nearFullMerged = byteMerge({15'h0, nearFullLvl}, wb_dat_i,
    wb_sel_i);

csf_ram #(
    .WIDTH(WIDTH),
    .AW(AW)
) ram (
    .clk(core_clk),
    .writeEnable(push),
    .writeAddr(wrPtr),
    .writeData(writeData),
    .readEnable(ramReadEn),
    .readAddr(ramReadAddr),
    .readData(ramData)
);

// pointers wrap at the power-of-two depth
always @(posedge core_clk) begin
    if (clear) begin
        wrPtr <= {AW{1'b0}};
        rdPtr <= {AW{1'b0}};
        count <= {(AW+1){1'b0}};
    end else begin
        if (push) begin
            wrPtr <= wrPtr + {{(AW-1){1'b0}}, 1'b1};
        end
        if (pop) begin
            rdPtr <= rdPtr + {{(AW-1){1'b0}}, 1'b1};
        end
        if (push && !pop) begin
            count <= count + {{AW{1'b0}}, 1'b1};
        end else if (pop && !push) begin
            count <= count - {{AW{1'b0}}, 1'b1};
        end
    end
end

// standard mode: data is valid for one cycle after the accepted read
always @(posedge core_clk) begin
    if (clear) begin
        stdValid <= 1'b0;
    end else if (ceOn) begin
        stdValid <= pop;
    end
end

// optional extra stage; costs a cycle but relaxes timing after the ram
always @(posedge core_clk) begin
    if (clear) begin
        pipeData <= OUT_RESET_VALUE;
        pipeValid <= 1'b0;
    end else if (ceOn) begin
        pipeData <= ramData;
        pipeValid <= headValid;
    end
end

assign readData = (OUT_REG != 0) ? pipeData : ramData;
assign readValid = (OUT_REG != 0) ? pipeValid : headValid;

assign full = isFull;
assign empty = isEmpty;

// a full queue saturates to all ones rather than wrapping to 0.0
assign fillFraction = count[AW] ? {FRAC_BITS{1'b1}} :
    count[AW-1 -: FRAC_BITS];

assign wordCount = (HAS_COUNT != 0) ? count : {(AW+1){1'b0}};

wire nearEmptyNow = (count17 <= nearEmptyLvl);
wire nearFullNow = (count17 >= nearFullLvl);
assign nearEmptyFlag = (HAS_NEAR_EMPTY != 0) && nearEmptyNow;
assign nearFullFlag = (HAS_NEAR_FULL != 0) && nearFullNow;

// previous flag values turn levels into entry events
always @(posedge core_clk) begin
    if (!reset_n) begin
        fullQ <= 1'b0;
        emptyQ <= 1'b1;
        nearEmptyQ <= 1'b1;
        nearFullQ <= 1'b0;
    end else begin
        fullQ <= isFull;
        emptyQ <= isEmpty;
        nearEmptyQ <= nearEmptyFlag;
        nearFullQ <= nearFullFlag;
    end
end

assign events[`CSF_EV_FULL] = isFull && !fullQ;
assign events[`CSF_EV_EMPTY] = isEmpty && !emptyQ;
assign events[`CSF_EV_NEAR_EMPTY] = nearEmptyFlag && !nearEmptyQ;
assign events[`CSF_EV_NEAR_FULL] = nearFullFlag && !nearFullQ;
assign events[`CSF_EV_OVERFLOW] = overflow;
assign events[`CSF_EV_UNDERFLOW] = underflow;

assign intClear = (wbWrite && wb_adr_i == `CSF_REG_INT_STATUS &&
    wb_sel_i[0]) ? wb_dat_i[`CSF_EV_W-1:0] : {`CSF_EV_W{1'b0}};

// a new event wins over a write-one-to-clear in the same cycle
always @* begin
    next_intStatus = (intStatus & ~intClear) | events;
end

always @(posedge core_clk) begin
    if (!reset_n) begin
        intStatus <= `CSF_INT_STATUS_RST;
    end else begin
        intStatus <= next_intStatus;
    end
end

assign irq = |(intStatus & intMask);

// classic wishbone: ack one cycle after the request, dropped the next
always @(posedge core_clk) begin
    if (!reset_n) begin
        wb_ack_o <= 1'b0;
    end else begin
        wb_ack_o <= wbReq && !wb_ack_o;
    end
end

// writable registers take effect on the acknowledged edge
always @(posedge core_clk) begin
    if (!reset_n) begin
        intMask <= `CSF_INT_MASK_RST;
        nearEmptyLvl <= `CSF_NEAR_EMPTY_RST;
        nearFullLvl <= FULL_LVL - `CSF_NEAR_MARGIN;
        flushReq <= 1'b0;
    end else begin
        flushReq <= wbWrite && wb_adr_i == `CSF_REG_CTRL &&
            wb_sel_i[0] && wb_dat_i[`CSF_CTRL_FLUSH];
        if (wbWrite) begin
            case (wb_adr_i)
                `CSF_REG_INT_MASK: begin
                    intMask <= maskMerged[`CSF_EV_W-1:0];
                end
                `CSF_REG_NEAR_EMPTY_LVL: begin
                    nearEmptyLvl <= nearEmptyMerged[`CSF_LVL_W-1:0];
                end
                `CSF_REG_NEAR_FULL_LVL: begin
                    nearFullLvl <= nearFullMerged[`CSF_LVL_W-1:0];
                end
                default: begin
                end
            endcase
        end
    end
end

assign statusWord = {11'h000, count17, nearFullNow, nearEmptyNow,
    isEmpty, isFull};

// unmapped offsets read zero and still acknowledge
always @* begin
    case (wb_adr_i)
        `CSF_REG_CTRL: next_rdata = 32'h00000000;
        `CSF_REG_STATUS: next_rdata = statusWord;
        `CSF_REG_INT_STATUS: next_rdata = {26'h0, intStatus};
        `CSF_REG_INT_MASK: next_rdata = {26'h0, intMask};
        `CSF_REG_NEAR_EMPTY_LVL: next_rdata = {15'h0, nearEmptyLvl};
        `CSF_REG_NEAR_FULL_LVL: next_rdata = {15'h0, nearFullLvl};
        default: next_rdata = 32'h00000000;
    endcase
end

always @(posedge core_clk) begin
    if (!reset_n) begin
        wb_dat_o <= 32'h00000000;
    end else if (wbReq && !wb_ack_o) begin
        wb_dat_o <= next_rdata;
    end
end

endmodule // csf_fifo

// ===== hdl/csf_map.vh
`ifndef CSF_MAP_VH
`define CSF_MAP_VH

// register byte offsets on the bus
`define CSF_REG_CTRL 8'h00
`define CSF_REG_STATUS 8'h04
`define CSF_REG_INT_STATUS 8'h08
`define CSF_REG_INT_MASK 8'h0C
`define CSF_REG_NEAR_EMPTY_LVL 8'h10
`define CSF_REG_NEAR_FULL_LVL 8'h14

// control register fields
`define CSF_CTRL_FLUSH 0

// status register fields
`define CSF_ST_FULL 0
`define CSF_ST_EMPTY 1
`define CSF_ST_NEAR_EMPTY 2
`define CSF_ST_NEAR_FULL 3
`define CSF_ST_COUNT_LSB 4

// event bits, shared by interrupt status and mask
`define CSF_EV_FULL 0
`define CSF_EV_EMPTY 1
`define CSF_EV_NEAR_EMPTY 2
`define CSF_EV_NEAR_FULL 3
`define CSF_EV_OVERFLOW 4
`define CSF_EV_UNDERFLOW 5
`define CSF_EV_W 6

// threshold width covers a count of up to 64K words
`define CSF_LVL_W 17

// reset values
`define CSF_INT_STATUS_RST 6'h00
`define CSF_INT_MASK_RST 6'h00
`define CSF_NEAR_EMPTY_RST 17'h00004
`define CSF_NEAR_MARGIN 17'h00004

`endif

// ===== hdl/csf_ram.v
module csf_ram #(
    parameter WIDTH = 16,
    parameter AW = 10
)(
    // clock
    input wire clk,
    // write port
    input wire writeEnable,
    input wire [AW-1:0] writeAddr,
    input wire [WIDTH-1:0] writeData,
    // read port
    input wire readEnable,
    input wire [AW-1:0] readAddr,
    output reg [WIDTH-1:0] readData
);

reg [WIDTH-1:0] mem [0:(1<<AW)-1];

always @(posedge clk) begin
    if (writeEnable) begin
        mem[writeAddr] <= writeData;
    end
end

// write-first: a word written into the address being read appears at once,
// so a look-ahead head never shows a stale location
always @(posedge clk) begin
    if (readEnable) begin
        if (writeEnable && writeAddr == readAddr) begin
            readData <= writeData;
        end else begin
            readData <= mem[readAddr];
        end
    end
end

endmodule // csf_ram

// ===== tb/csf_fifo_assertions.sv
module csf_fifo_assertions #(
    parameter DEPTH = 16,
    parameter FRAC_BITS = 2
)(
    // clock and reset
    input wire core_clk,
    input wire reset_n,
    // queue controls
    input wire fifoReset,
    input wire clockEnable,
    input wire writeEnable,
    input wire readEnable,
    // status
    input wire full,
    input wire empty,
    input wire readValid,
    input wire [FRAC_BITS-1:0] fillFraction,
    input wire [$clog2(DEPTH):0] wordCount,
    input wire irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    wire go = clockEnable && !fifoReset;

    full_tracks_count_a: assert property (full == (wordCount == DEPTH))
        else $error("full flag disagrees with word count");
    empty_tracks_count_a: assert property (empty == (wordCount == 0))
        else $error("empty flag disagrees with word count");
    push_counts_up_a: assert property (go && writeEnable && !full &&
        !readEnable |=> wordCount == $past(wordCount) + 1)
        else $error("accepted push did not add one word");
    full_write_ignored_a: assert property (go && writeEnable && full &&
        !readEnable |=> wordCount == $past(wordCount))
        else $error("push while full changed the count");
    empty_read_ignored_a: assert property (go && readEnable && empty &&
        !writeEnable |=> !readValid && empty)
        else $error("pop while empty was not ignored");
    pop_gives_valid_a: assert property (go && readEnable && !empty
        |=> readValid ##1 !readValid || $past(readEnable))
        else $error("pop not answered next cycle");
    valid_needs_pop_a: assert property ($rose(readValid)
        |-> $past(readEnable && !empty && clockEnable))
        else $error("data valid without a pop");
    half_fraction_a: assert property (fillFraction[FRAC_BITS-1] ==
        (wordCount >= DEPTH / 2))
        else $error("fill fraction top bit wrong");
    enable_hold_a: assert property (!clockEnable && !fifoReset
        |=> $stable(wordCount))
        else $error("count moved while disabled");
    queue_clear_a: assert property (fifoReset |=> empty)
        else $error("queue reset did not empty");

    cover property (full);
    cover property (readValid);
    cover property (irq);
endmodule // csf_fifo_assertions

bind csf_fifo csf_fifo_assertions #(.DEPTH(DEPTH), .FRAC_BITS(FRAC_BITS)) chk (
    .core_clk(core_clk), .reset_n(reset_n), .fifoReset(fifoReset),
    .clockEnable(clockEnable), .writeEnable(writeEnable),
    .readEnable(readEnable), .full(full), .empty(empty),
    .readValid(readValid), .fillFraction(fillFraction),
    .wordCount(wordCount), .irq(irq));

// ===== tb/csf_partner.sv
module csf_partner (
    // clock
    input wire core_clk,
    // queue status
    input wire full,
    input wire empty,
    input wire readValid,
    input wire [15:0] readData,
    // requests
    output logic writeEnable = 1'b0,
    output logic [15:0] writeData = 16'h0000,
    output logic readEnable = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;

    // a well-behaved producer stays off a full queue unless told to misbehave
    task automatic push(input logic [15:0] word, input bit rude);
        @(posedge core_clk);
        writeEnable <= !full || rude;
        writeData <= word;
        @(posedge core_clk);
        writeEnable <= 1'b0;
        writeData <= ~word;
        #1;
    endtask

    task automatic pop(output logic [15:0] word, output logic valid,
                       input bit rude);
        @(posedge core_clk);
        readEnable <= !empty || rude;
        @(posedge core_clk);
        readEnable <= 1'b0;
        #1;
        valid = readValid;
        word = readData;
    endtask
endmodule // csf_partner

// ===== tb/testbench.sv
`include "csf_map.vh"
`define CHECK(g, e) begin total_checks++; if ((g) !== (e)) begin \
    bad_count++; $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam DEPTH = 16;
    logic core_clk = 0, reset_n = 0, fifoReset = 0, clockEnable = 1;
    logic wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
    wire writeEnable, readEnable, full, empty, readValid, wb_ack_o, irq;
    wire nearEmptyFlag, nearFullFlag;
    wire [15:0] writeData, readData;
    wire [1:0] fillFraction;
    wire [4:0] wordCount;
    logic [15:0] got;
    logic v;
    int bad_count = 0, total_checks = 0, n;

    csf_fifo #(.WIDTH(16), .DEPTH(DEPTH), .FRAC_BITS(2)) dut (
        .core_clk(core_clk), .reset_n(reset_n), .fifoReset(fifoReset),
        .clockEnable(clockEnable), .writeEnable(writeEnable),
        .writeData(writeData), .full(full), .readEnable(readEnable),
        .readData(readData), .readValid(readValid), .empty(empty),
        .fillFraction(fillFraction), .wordCount(wordCount),
        .nearEmptyFlag(nearEmptyFlag), .nearFullFlag(nearFullFlag),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq(irq));
    csf_partner prt (
        .core_clk(core_clk), .full(full), .empty(empty),
        .readValid(readValid), .readData(readData),
        .writeEnable(writeEnable), .writeData(writeData),
        .readEnable(readEnable));

    initial begin
        forever #25 core_clk = ~core_clk;
    end

    task automatic results();
        $display("checks=%0d mismatches=%0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic wb(input logic we, input logic [7:0] adr,
                      input logic [31:0] dat);
        int i;
        @(posedge core_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        for (i = 0; i < 20; i++) begin
            @(posedge core_clk);
            if (wb_ack_o === 1'b1) break;
        end
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (i == 20) begin
            bad_count++;
            results();
        end
    endtask

    initial begin
        repeat (5) @(posedge core_clk);
        reset_n <= 1'b1;
        #1;
        `CHECK({empty, full, wordCount}, 7'h40)
        wb(0, `CSF_REG_INT_MASK, 0); `CHECK(rd, 32'h0)
        wb(0, `CSF_REG_NEAR_EMPTY_LVL, 0); `CHECK(rd, 32'h4)
        wb(0, `CSF_REG_NEAR_FULL_LVL, 0); `CHECK(rd, DEPTH - 4)
        wb(0, 8'h40, 0); `CHECK(rd, 32'h0)
        wb(1, `CSF_REG_INT_MASK, 32'h11);
        for (n = 1; n <= DEPTH; n++) begin
            prt.push(16'hA500 + n, 0);
            `CHECK(wordCount, 5'(n))
            `CHECK(nearEmptyFlag, n <= 4)
            `CHECK(nearFullFlag, n >= DEPTH - 4)
            `CHECK(fillFraction, n == DEPTH ? 2'h3 : 2'(n * 4 / DEPTH))
        end
        @(posedge core_clk);
        #1;
        `CHECK({full, irq}, 2'h3)
        prt.push(16'hDEAD, 1);
        `CHECK(wordCount, 5'(DEPTH))
        wb(0, `CSF_REG_INT_STATUS, 0); `CHECK(rd[4], 1'b1)
        clockEnable <= 1'b0;
        prt.pop(got, v, 0);
        `CHECK({v, wordCount}, 6'(DEPTH))
        clockEnable <= 1'b1;
        for (n = 1; n <= DEPTH; n++) begin
            prt.pop(got, v, 0);
            `CHECK({v, got}, {1'b1, 16'hA500 + 16'(n)})
        end
        `CHECK(empty, 1'b1)
        prt.pop(got, v, 1);
        `CHECK({v, empty}, 2'h1)
        wb(0, `CSF_REG_INT_STATUS, 0); `CHECK(rd[5], 1'b1)
        wb(1, `CSF_REG_INT_STATUS, 32'h3F);
        wb(0, `CSF_REG_INT_STATUS, 0); `CHECK({rd, irq}, 33'h0)
        prt.push(16'h0001, 0);
        @(posedge core_clk) fifoReset <= 1'b1;
        @(posedge core_clk) fifoReset <= 1'b0;
        #1;
        `CHECK({empty, wordCount}, 6'h20)
        prt.push(16'h0002, 0);
        wb(1, `CSF_REG_CTRL, 32'h1);
        @(posedge core_clk);
        #1;
        `CHECK({empty, wordCount}, 6'h20)
        wb(0, `CSF_REG_STATUS, 0); `CHECK(rd, 32'h6)
        results();
    end
endmodule // testbench
